// ### iomc_cmd_master.v
// Host controller writing the IO module command register block
//
// What this block does
// - Generic codes 1672 output state, 41099 alarm reset, 41100 simple enable.
// - Generic codes 41102 latched acknowledge, 42890 analog min/max reset.
// - Application codes 41352 cradle counters, 41353 regrease timers, 42120 light.
// - Application codes 42376 load, 42888 pulse counter, 42889 temperature counter.
// - Code goes to word 0x1F3F, byte count to 0x1F40; output change uses 13.
// - Destination word 0x1F41: 8193 first module, 8449 second module.
// - Security type word 0x1F42 always written as 1.
// - Password occupies words 0x1F43 and 0x1F44 for every command.
// - Output number 1..3 in 0x1F45; 0x0000 in 0x1F46 turns it off.
// - Alarm reset declares ten bytes and sends no parameter words.
// - Simple enable uses eleven bytes; high byte 1 enables, 0 disables.
`timescale 1ns/1ps
`include "iomc_consts.vh"

module iomc_cmd_master #(
  parameter [31:0] RSP_TIMEOUT_CYC = `IOMC_RSP_TIMEOUT_US * `IOMC_CLK_MHZ
) (
  input  wire                    ref_clk,
  input  wire                    arst_n,
  input  wire                    clk_en,
  input  wire                    cmd_valid,
  output reg                     cmd_ready_q,
  input  wire [15:0]             cmd_code,
  input  wire                    cmd_module,
  input  wire [31:0]             cmd_password,
  input  wire [7:0]              cmd_nbytes,
  input  wire [1:0]              cmd_out_num,
  input  wire                    cmd_out_on,
  input  wire                    cmd_simple_en,
  input  wire [7:0]              cmd_latch_sel,
  input  wire [63:0]             cmd_raw_args,
  input  wire [`IOMC_APP_W-1:0]  app_cfg,
  output reg                     res_valid_q,
  output reg  [1:0]              res_kind_q,
  output reg  [15:0]             res_err_code_q,
  output reg                     dev_wr_q,
  output reg  [15:0]             dev_addr_q,
  output reg  [15:0]             dev_wdata_q,
  input  wire                    dev_accept,
  input  wire                    dev_rsp_valid,
  input  wire                    dev_rsp_err,
  input  wire [15:0]             dev_rsp_code
);

  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_WRITE = 2'h1;
  localparam [1:0] S_WAIT  = 2'h2;
  localparam [1:0] S_DONE  = 2'h3;

  wire        known;
  wire        app_ok;
  wire [7:0]  nbytes;
  wire [2:0]  nwords;
  wire [63:0] args;
  wire        args_ok;

  iomc_code_check u_check (
    .code        (cmd_code),
    .app_cfg     (app_cfg),
    .user_nbytes (cmd_nbytes),
    .known       (known),
    .app_ok      (app_ok),
    .nbytes      (nbytes),
    .nwords      (nwords)
  );

  iomc_arg_pack u_pack (
    .code      (cmd_code),
    .out_num   (cmd_out_num),
    .out_on    (cmd_out_on),
    .simple_en (cmd_simple_en),
    .latch_sel (cmd_latch_sel),
    .raw_args  (cmd_raw_args),
    .args      (args),
    .args_ok   (args_ok)
  );

  reg  [1:0]  state_q;
  reg  [3:0]  idx_q;
  reg  [3:0]  last_q;
  reg  [15:0] code_q;
  reg  [7:0]  nbytes_q;
  reg         module_q;
  reg  [31:0] pw_q;
  reg  [63:0] args_q;
  reg  [17:0] tmo_q;

  wire take = cmd_valid && cmd_ready_q;
  // host side screening before any write
  wire cmd_ok = known && app_ok && args_ok;

  // Word for slot i of the block; slots run from the code word upward
  function [15:0] word_at;
    input [3:0]  i;
    input [15:0] code;
    input [7:0]  nb;
    input        modsel;
    input [31:0] pw;
    input [63:0] a;
    begin
      case (i)
        4'h0: word_at = code;
        4'h1: word_at = {8'h00, nb};
        4'h2: word_at = modsel ? `IOMC_DEST_MOD2 : `IOMC_DEST_MOD1;
        4'h3: word_at = `IOMC_SECURITY_TYPE;
        4'h4: word_at = pw[31:16];
        4'h5: word_at = pw[15:0];
        4'h6: word_at = a[15:0];
        4'h7: word_at = a[31:16];
        4'h8: word_at = a[47:32];
        4'h9: word_at = a[63:48];
        default: word_at = 16'h0000;
      endcase
    end
  endfunction

  wire [3:0]  idx_nx  = idx_q + 4'h1;
  wire [15:0] word_nx = word_at(idx_nx, code_q, nbytes_q, module_q, pw_q, args_q);
  wire        tmo_hit = ({14'h0000, tmo_q} >= RSP_TIMEOUT_CYC - 32'h0000_0001);

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q        <= S_IDLE;
      cmd_ready_q    <= 1'b0;
      res_valid_q    <= 1'b0;
      res_kind_q     <= `IOMC_RES_OK;
      res_err_code_q <= 16'h0000;
      dev_wr_q       <= 1'b0;
      dev_addr_q     <= 16'h0000;
      dev_wdata_q    <= 16'h0000;
      idx_q          <= 4'h0;
      last_q         <= 4'h0;
      code_q         <= 16'h0000;
      nbytes_q       <= 8'h00;
      module_q       <= 1'b0;
      pw_q           <= 32'h0000_0000;
      args_q         <= 64'h0000_0000_0000_0000;
      tmo_q          <= 18'h0_0000;
    end
    else if (clk_en)
    begin
      res_valid_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          cmd_ready_q <= 1'b1;
          if (take)
          begin
            cmd_ready_q <= 1'b0;
            code_q      <= cmd_code;
            nbytes_q    <= nbytes;
            module_q    <= cmd_module;
            pw_q        <= cmd_password;
            args_q      <= args;
            // zero words leaves last slot at the password
            last_q      <= 4'h5 + {1'b0, nwords};
            idx_q       <= 4'h0;
            if (cmd_ok)
            begin
              state_q     <= S_WRITE;
              dev_wr_q    <= 1'b1;
              dev_addr_q  <= `IOMC_OFS_CODE;
              dev_wdata_q <= cmd_code;
            end
            else
            begin
              state_q        <= S_DONE;
              res_valid_q    <= 1'b1;
              res_kind_q     <= `IOMC_RES_REJECT;
              res_err_code_q <= 16'h0000;
            end
          end
        end
        S_WRITE:
        begin
          // Word held until the device takes it
          if (dev_accept)
          begin
            if (idx_q == last_q)
            begin
              dev_wr_q <= 1'b0;
              tmo_q    <= 18'h0_0000;
              state_q  <= S_WAIT;
            end
            else
            begin
              idx_q       <= idx_nx;
              dev_addr_q  <= dev_addr_q + 16'h0001;
              dev_wdata_q <= word_nx;
            end
          end
        end
        S_WAIT:
        begin
          tmo_q <= tmo_q + 18'h0_0001;
          if (dev_rsp_valid)
          begin
            state_q        <= S_DONE;
            res_valid_q    <= 1'b1;
            res_kind_q     <= dev_rsp_err ? `IOMC_RES_DEV_ERR : `IOMC_RES_OK;
            res_err_code_q <= dev_rsp_err ? dev_rsp_code : 16'h0000;
          end
          else if (tmo_hit)
          begin
            // A silent device must not hang the user port
            state_q        <= S_DONE;
            res_valid_q    <= 1'b1;
            res_kind_q     <= `IOMC_RES_TIMEOUT;
            res_err_code_q <= 16'h0000;
          end
        end
        default:
        begin
          state_q     <= S_IDLE;
          cmd_ready_q <= 1'b1;
        end
      endcase
    end
  end

endmodule // iomc_cmd_master

// ### iomc_consts.vh
// Constants for the IO module command master
`ifndef IOMC_CONSTS_VH
`define IOMC_CONSTS_VH

// Command register block, word addresses
`define IOMC_OFS_CODE      16'h1F3F
`define IOMC_OFS_NBYTES    16'h1F40
`define IOMC_OFS_DEST      16'h1F41
`define IOMC_OFS_SECURITY  16'h1F42
`define IOMC_OFS_PW_HI     16'h1F43
`define IOMC_OFS_PW_LO     16'h1F44
`define IOMC_OFS_ARG0      16'h1F45
`define IOMC_OFS_ARG1      16'h1F46

// Generic command codes
`define IOMC_CMD_OUT_STATE   16'h0688
`define IOMC_CMD_ALARM_RST   16'hA08B
`define IOMC_CMD_SIMPLE_EN   16'hA08C
`define IOMC_CMD_LATCH_ACK   16'hA08E
`define IOMC_CMD_AIN_MINMAX  16'hA78A
// Application command codes
`define IOMC_CMD_CRADLE_CNT  16'hA188
`define IOMC_CMD_REGREASE    16'hA189
`define IOMC_CMD_LIGHT       16'hA488
`define IOMC_CMD_LOAD        16'hA588
`define IOMC_CMD_PULSE_CNT   16'hA788
`define IOMC_CMD_TEMP_CNT    16'hA789

// Parameter byte counts
`define IOMC_NB_OUT_STATE    8'h0D
`define IOMC_NB_ALARM_RST    8'h0A
`define IOMC_NB_SIMPLE_EN    8'h0B
`define IOMC_NB_LATCH_ACK    8'h0B
`define IOMC_NB_AIN_MINMAX   8'h0A
`define IOMC_NB_CRADLE_CNT   8'h10
`define IOMC_NB_REGREASE     8'h12
`define IOMC_NB_LIGHT        8'h0D
`define IOMC_NB_BASE         8'h0A

// Parameter word counts following the password
`define IOMC_NW_OUT_STATE    3'h2
`define IOMC_NW_SIMPLE_EN    3'h1
`define IOMC_NW_LATCH_ACK    3'h1
`define IOMC_NW_CRADLE_CNT   3'h3
`define IOMC_NW_REGREASE     3'h4
`define IOMC_NW_LIGHT        3'h2
`define IOMC_NW_MAX          3'h4

// Destination and security words
`define IOMC_DEST_MOD1       16'h2001
`define IOMC_DEST_MOD2       16'h2101
`define IOMC_SECURITY_TYPE   16'h0001

// Argument values
`define IOMC_OUT_OFF         16'h0000
`define IOMC_OUT_ON          16'h0100
`define IOMC_OUT_NUM_MIN     2'h1
`define IOMC_OUT_NUM_MAX     2'h3
`define IOMC_LATCH_MIN       8'h01
`define IOMC_LATCH_MAX       8'h03
`define IOMC_LATCH_ALL       8'hFF

// Application configuration mask bits
`define IOMC_APP_CRADLE      3'h0
`define IOMC_APP_LIGHT       3'h1
`define IOMC_APP_LOAD        3'h2
`define IOMC_APP_PULSE       3'h3
`define IOMC_APP_COOLING     3'h4
`define IOMC_APP_W           5

// Result kinds
`define IOMC_RES_OK          2'h0
`define IOMC_RES_DEV_ERR     2'h1
`define IOMC_RES_REJECT      2'h2
`define IOMC_RES_TIMEOUT     2'h3

// Timing
`define IOMC_CLK_MHZ         200
`define IOMC_RSP_TIMEOUT_US  1000

`endif

// ### iomc_code_check.v
// Command code table: known codes, byte counts and parameter word counts
`timescale 1ns/1ps
`include "iomc_consts.vh"

module iomc_code_check (
  input  wire [15:0]            code,
  input  wire [`IOMC_APP_W-1:0] app_cfg,
  input  wire [7:0]             user_nbytes,
  output reg                    known,
  output reg                    app_ok,
  output reg  [7:0]             nbytes,
  output reg  [2:0]             nwords
);

  reg       is_app;
  reg [2:0] app_bit;
  reg [7:0] extra;

  always @*
  begin
    known   = 1'b1;
    is_app  = 1'b0;
    app_bit = 3'h0;
    nbytes  = `IOMC_NB_BASE;
    nwords  = 3'h0;
    extra   = 8'h00;
    case (code)
      `IOMC_CMD_OUT_STATE:
      begin
        nbytes = `IOMC_NB_OUT_STATE;
        nwords = `IOMC_NW_OUT_STATE;
      end
      `IOMC_CMD_ALARM_RST: nbytes = `IOMC_NB_ALARM_RST;
      `IOMC_CMD_SIMPLE_EN:
      begin
        nbytes = `IOMC_NB_SIMPLE_EN;
        nwords = `IOMC_NW_SIMPLE_EN;
      end
      `IOMC_CMD_LATCH_ACK:
      begin
        nbytes = `IOMC_NB_LATCH_ACK;
        nwords = `IOMC_NW_LATCH_ACK;
      end
      `IOMC_CMD_AIN_MINMAX: nbytes = `IOMC_NB_AIN_MINMAX;
      `IOMC_CMD_CRADLE_CNT:
      begin
        is_app = 1'b1;
        nbytes = `IOMC_NB_CRADLE_CNT;
        nwords = `IOMC_NW_CRADLE_CNT;
      end
      `IOMC_CMD_REGREASE:
      begin
        is_app = 1'b1;
        nbytes = `IOMC_NB_REGREASE;
        nwords = `IOMC_NW_REGREASE;
      end
      `IOMC_CMD_LIGHT:
      begin
        is_app  = 1'b1;
        app_bit = `IOMC_APP_LIGHT;
        nbytes  = `IOMC_NB_LIGHT;
        nwords  = `IOMC_NW_LIGHT;
      end
      `IOMC_CMD_LOAD, `IOMC_CMD_PULSE_CNT, `IOMC_CMD_TEMP_CNT:
      begin
        is_app  = 1'b1;
        app_bit = (code == `IOMC_CMD_LOAD) ? `IOMC_APP_LOAD :
                  (code == `IOMC_CMD_PULSE_CNT) ? `IOMC_APP_PULSE : `IOMC_APP_COOLING;
        nbytes  = user_nbytes;
        extra   = user_nbytes - `IOMC_NB_BASE;
        // Odd byte counts round up to a whole word
        nwords  = (user_nbytes < `IOMC_NB_BASE) ? 3'h0 :
                  (extra > 8'h08) ? `IOMC_NW_MAX : extra[3:1] + {2'b00, extra[0]};
        known   = (user_nbytes >= `IOMC_NB_BASE) && (extra <= 8'h08);
      end
      default: known = 1'b0;
    endcase
    app_ok = !is_app || app_cfg[app_bit];
  end

endmodule // iomc_code_check

// ### iomc_arg_pack.v
// Builds the parameter words for generic commands, raw words otherwise
`timescale 1ns/1ps
`include "iomc_consts.vh"

module iomc_arg_pack (
  input  wire [15:0] code,
  input  wire [1:0]  out_num,
  input  wire        out_on,
  input  wire        simple_en,
  input  wire [7:0]  latch_sel,
  input  wire [63:0] raw_args,
  output wire [63:0] args,
  output wire        args_ok
);

  wire is_out   = (code == `IOMC_CMD_OUT_STATE);
  wire is_simp  = (code == `IOMC_CMD_SIMPLE_EN);
  wire is_latch = (code == `IOMC_CMD_LATCH_ACK);

  wire [15:0] packed_w [0:3];
  assign packed_w[0] = is_out ? {14'h0000, out_num} :
                       // enable in high byte, low byte zero
                       is_simp ? {7'h00, simple_en, 8'h00} :
                       {latch_sel, 8'h00};
  assign packed_w[1] = out_on ? `IOMC_OUT_ON : `IOMC_OUT_OFF;
  assign packed_w[2] = 16'h0000;
  assign packed_w[3] = 16'h0000;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_word
      assign args[16*i+15:16*i] = (is_out || is_simp || is_latch) ? packed_w[i] : raw_args[16*i+15:16*i];
    end
  endgenerate

  assign args_ok = is_out ? (out_num >= `IOMC_OUT_NUM_MIN && out_num <= `IOMC_OUT_NUM_MAX) :
                   is_latch ? ((latch_sel >= `IOMC_LATCH_MIN && latch_sel <= `IOMC_LATCH_MAX) ||
                               latch_sel == `IOMC_LATCH_ALL) :
                   1'b1;

endmodule // iomc_arg_pack

// ### iomc_cmd_master_chk.sv
// Port assertions for the IO module command master
`timescale 1ns/1ps
module iomc_chk #(
  parameter [31:0] RSP_TIMEOUT_CYC = 32'd20
) (
  input wire        ref_clk,
  input wire        arst_n,
  input wire        cmd_valid,
  input wire        cmd_ready_q,
  input wire        res_valid_q,
  input wire [1:0]  res_kind_q,
  input wire [15:0] res_err_code_q,
  input wire        dev_wr_q,
  input wire [15:0] dev_addr_q,
  input wire [15:0] dev_wdata_q,
  input wire        dev_accept,
  input wire        dev_rsp_valid,
  input wire        dev_rsp_err,
  input wire [15:0] dev_rsp_code
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // Cycles spent waiting for an answer after the last word
  reg [31:0] wait_cyc;
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
      wait_cyc <= 32'h0000_0000;
    else if (res_valid_q || dev_wr_q || cmd_ready_q)
      wait_cyc <= 32'h0000_0000;
    else
      wait_cyc <= wait_cyc + 32'h0000_0001;

  a_wr_hold: assert property (dev_wr_q && !dev_accept |=>
    dev_wr_q && $stable(dev_addr_q) && $stable(dev_wdata_q)) else $error("write changed before accept");
  a_addr_step: assert property (dev_wr_q && dev_accept ##1 dev_wr_q |->
    dev_addr_q == $past(dev_addr_q) + 16'h0001) else $error("address did not step by one");
  a_first_word: assert property ($rose(dev_wr_q) |-> dev_addr_q == 16'h1F3F && dev_wdata_q inside
    {16'h0688, 16'hA08B, 16'hA08C, 16'hA08E, 16'hA78A, 16'hA188, 16'hA189, 16'hA488, 16'hA588, 16'hA788,
    16'hA789}) else $error("block did not open with a known code");
  a_count_word: assert property (dev_wr_q && dev_addr_q == 16'h1F40 |->
    dev_wdata_q[15:8] == 8'h00 && dev_wdata_q[7:0] inside {[8'h0A:8'h12]}) else $error("bad byte count");
  a_dest_word: assert property (dev_wr_q && dev_addr_q == 16'h1F41 |->
    dev_wdata_q == 16'h2001 || dev_wdata_q == 16'h2101) else $error("bad destination");
  a_sec_word: assert property (dev_wr_q && dev_addr_q == 16'h1F42 |->
    dev_wdata_q == 16'h0001) else $error("bad security type");
  a_res_ready: assert property (res_valid_q |-> !cmd_ready_q ##1 (cmd_ready_q && !res_valid_q))
    else $error("result pulse or ready timing wrong");
  a_take_busy: assert property (cmd_valid && cmd_ready_q |=> !cmd_ready_q) else $error("ready stayed high");
  a_reject_fast: assert property (res_valid_q && res_kind_q == 2'h2 |->
    $past(cmd_valid && cmd_ready_q) && !$past(dev_wr_q)) else $error("reject late or after writes");
  a_tmo_bound: assert property (wait_cyc <= RSP_TIMEOUT_CYC) else $error("no result within timeout");
  a_err_pass: assert property (res_valid_q && res_kind_q == 2'h1 |->
    $past(dev_rsp_valid && dev_rsp_err) && res_err_code_q == $past(dev_rsp_code)) else $error("error code lost");

  c_ok: cover property (res_valid_q && res_kind_q == 2'h0);
  c_reject: cover property (res_valid_q && res_kind_q == 2'h2);
  c_timeout: cover property (res_valid_q && res_kind_q == 2'h3);
endmodule // iomc_chk

bind iomc_cmd_master iomc_chk #(.RSP_TIMEOUT_CYC(RSP_TIMEOUT_CYC)) u_chk (.ref_clk, .arst_n, .cmd_valid,
  .cmd_ready_q, .res_valid_q, .res_kind_q, .res_err_code_q, .dev_wr_q, .dev_addr_q, .dev_wdata_q, .dev_accept,
  .dev_rsp_valid, .dev_rsp_err, .dev_rsp_code);

// ### iomc_dev_model.sv
// Behavioural IO module holding the command register block
`timescale 1ns/1ps
module iomc_dev_model #(
  parameter [31:0] PASS_WORD = 32'hC0DE_5EED,
  parameter [15:0] ERR_CODE  = 16'h0042,
  parameter [7:0]  RSP_DLY   = 8'h03,
  // Outputs 1 and 2 user-defined, output 3 assigned elsewhere
  parameter [3:1]  USER_OUTS = 3'h3
) (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        dev_wr_q,
  input  wire [15:0] dev_addr_q,
  input  wire [15:0] dev_wdata_q,
  input  wire        slow,
  input  wire        mute,
  output reg         dev_accept,
  output reg         dev_rsp_valid,
  output reg         dev_rsp_err,
  output reg  [15:0] dev_rsp_code
);
  reg  [15:0] mem [0:15];
  reg  [3:0]  n;
  reg         pend;
  reg         bad;
  reg  [7:0]  dly;
  reg  [3:1]  outs;
  wire [15:0] idx = dev_addr_q - 16'h1F3F;

  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      dev_accept <= 1'b0;
      dev_rsp_valid <= 1'b0;
      dev_rsp_err <= 1'b0;
      dev_rsp_code <= 16'h0000;
      n <= 4'h0;
      pend <= 1'b0;
      bad <= 1'b0;
      dly <= 8'h00;
      outs <= 3'h0;
    end
    else
    begin
      dev_accept <= slow ? ~dev_accept : 1'b1;
      dev_rsp_valid <= 1'b0;
      // Idle answer lines wander so stale values never look valid
      dev_rsp_err <= ~dev_rsp_err;
      dev_rsp_code <= ~dev_rsp_code;
      if (dev_wr_q && dev_accept)
      begin
        mem[idx[3:0]] <= dev_wdata_q;
        n <= (idx == 16'h0000) ? 4'h1 : n + 4'h1;
        pend <= 1'b1;
        dly <= 8'h00;
        if (idx == 16'h0000)
          bad <= 1'b0;
        else if ((idx == 16'h0002 && dev_wdata_q != 16'h2001 && dev_wdata_q != 16'h2101) ||
                 (idx == 16'h0003 && dev_wdata_q != 16'h0001) ||
                 (idx == 16'h0004 && dev_wdata_q != PASS_WORD[31:16]) ||
                 (idx == 16'h0005 && dev_wdata_q != PASS_WORD[15:0]))
          bad <= 1'b1;
      end
      else if (pend && !dev_wr_q)
      begin
        dly <= dly + 8'h01;
        if (dly == RSP_DLY)
        begin
          pend <= 1'b0;
          dev_rsp_valid <= !mute;
          dev_rsp_err <= bad;
          dev_rsp_code <= bad ? ERR_CODE : 16'h0000;
          if (!bad && mem[0] == 16'h0688 && mem[6] >= 16'h0001 && mem[6] <= 16'h0003 && USER_OUTS[mem[6][1:0]])
            outs[mem[6][1:0]] <= (mem[7] == 16'h0100);
        end
      end
    end
endmodule // iomc_dev_model

// ### iomc_tb.sv
// Self-checking bench for the IO module command master
`timescale 1ns/1ps
module tb;
  reg         ref_clk, arst_n, cmd_valid, cmd_module, cmd_out_on, cmd_simple_en, slow, mute;
  reg  [15:0] cmd_code;
  reg  [31:0] cmd_password;
  reg  [7:0]  cmd_nbytes, cmd_latch_sel;
  reg  [1:0]  cmd_out_num;
  reg  [4:0]  app_cfg;
  wire        cmd_ready_q, res_valid_q, dev_wr_q, dev_accept, dev_rsp_valid, dev_rsp_err;
  wire [1:0]  res_kind_q;
  wire [15:0] res_err_code_q, dev_addr_q, dev_wdata_q, dev_rsp_code;
  integer     bad_count, checked, cyc;

  iomc_cmd_master #(.RSP_TIMEOUT_CYC(32'd20)) dut (.ref_clk, .arst_n, .clk_en(1'b1), .cmd_valid, .cmd_ready_q,
    .cmd_code, .cmd_module, .cmd_password, .cmd_nbytes, .cmd_out_num, .cmd_out_on, .cmd_simple_en,
    .cmd_latch_sel, .cmd_raw_args(64'h4444_3333_2222_1111), .app_cfg, .res_valid_q, .res_kind_q,
    .res_err_code_q, .dev_wr_q, .dev_addr_q, .dev_wdata_q, .dev_accept, .dev_rsp_valid, .dev_rsp_err,
    .dev_rsp_code);
  iomc_dev_model dev (.ref_clk, .arst_n, .dev_wr_q, .dev_addr_q, .dev_wdata_q, .slow, .mute, .dev_accept,
    .dev_rsp_valid, .dev_rsp_err, .dev_rsp_code);

  task wrap_up;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk_word(input [15:0] g, input [15:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  task chk_kind(input [1:0] g, input [1:0] e);
    begin
      chk_word({14'h0000, g}, {14'h0000, e});
    end
  endtask

  // One command: sel feeds output number, on/off, enable and latch code
  task go(input [15:0] c, input [4:0] cfg, input [7:0] nb, input [7:0] sel, input int ek, input int enw,
          input [15:0] ea0, input [15:0] ea1);
    integer i;
    begin
      cmd_code = c;
      app_cfg = cfg;
      cmd_nbytes = nb;
      cmd_out_num = sel[1:0];
      cmd_simple_en = sel[0];
      cmd_out_on = sel[2];
      cmd_latch_sel = sel;
      cmd_valid = 1'b1;
      i = 0;
      while (cmd_ready_q !== 1'b1 && i < 50)
      begin
        @(posedge ref_clk);
        #1;
        i = i + 1;
      end
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      i = 0;
      while (res_valid_q !== 1'b1 && i < 200)
      begin
        @(posedge ref_clk);
        #1;
        i = i + 1;
      end
      chk_word({15'h0000, res_valid_q}, 16'h0001);
      chk_word({15'h0000, cmd_ready_q}, 16'h0000);
      chk_kind(res_kind_q, ek[1:0]);
      if (ek == 1)
        chk_word(res_err_code_q, 16'h0042);
      else
        chk_word(res_err_code_q, 16'h0000);
      if (ek != 2)
      begin
        chk_word(dev.mem[0], c);
        chk_word(dev.mem[1], {8'h00, nb});
        chk_word(dev.mem[2], cmd_module ? 16'h2101 : 16'h2001);
        chk_word(dev.mem[3], 16'h0001);
        chk_word(dev.mem[4], cmd_password[31:16]);
        chk_word(dev.mem[5], cmd_password[15:0]);
        chk_word({12'h000, dev.n}, 16'h0006 + enw[15:0]);
        if (enw > 0)
          chk_word(dev.mem[6], ea0);
        if (enw > 1)
          chk_word(dev.mem[7], ea1);
        if (enw > 2)
          chk_word(dev.mem[8], 16'h3333);
        if (enw > 3)
          chk_word(dev.mem[9], 16'h4444);
      end
      cmd_module = ~cmd_module;
    end
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    // Whole run needs about 320 cycles
    if (cyc == 5000)
    begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end

  initial
  begin
    {arst_n, cmd_valid, cmd_module, cmd_out_on, cmd_simple_en, slow, mute} = 7'h00;
    {cmd_code, cmd_nbytes, cmd_latch_sel, cmd_out_num, app_cfg} = 39'h00_0000_0000;
    cmd_password = 32'hC0DE_5EED;
    bad_count = 0;
    checked = 0;
    cyc = 0;
    repeat (6) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    go(16'h0688, 5'h00, 8'h0D, 8'h07, 0, 2, 16'h0003, 16'h0100);
    go(16'h0688, 5'h00, 8'h0D, 8'h05, 0, 2, 16'h0001, 16'h0100);
    chk_word({13'h0000, dev.outs}, 16'h0001);
    go(16'h0688, 5'h00, 8'h0D, 8'h01, 0, 2, 16'h0001, 16'h0000);
    chk_word({13'h0000, dev.outs}, 16'h0000);
    slow = 1'b1;
    go(16'hA08B, 5'h00, 8'h0A, 8'h00, 0, 0, 16'h0000, 16'h0000);
    go(16'hA08C, 5'h00, 8'h0B, 8'h01, 0, 1, 16'h0100, 16'h0000);
    go(16'hA08C, 5'h00, 8'h0B, 8'h00, 0, 1, 16'h0000, 16'h0000);
    go(16'hA08E, 5'h00, 8'h0B, 8'hFF, 0, 1, 16'hFF00, 16'h0000);
    go(16'hA08E, 5'h00, 8'h0B, 8'h02, 0, 1, 16'h0200, 16'h0000);
    go(16'hA78A, 5'h00, 8'h0A, 8'h00, 0, 0, 16'h0000, 16'h0000);
    slow = 1'b0;
    $display("test generic done");
    go(16'hA188, 5'h00, 8'h10, 8'h00, 2, 0, 16'h0000, 16'h0000);
    go(16'hA188, 5'h01, 8'h10, 8'h00, 0, 3, 16'h1111, 16'h2222);
    go(16'hA189, 5'h01, 8'h12, 8'h00, 0, 4, 16'h1111, 16'h2222);
    go(16'hA488, 5'h02, 8'h0D, 8'h00, 0, 2, 16'h1111, 16'h2222);
    go(16'hA488, 5'h1D, 8'h0D, 8'h00, 2, 0, 16'h0000, 16'h0000);
    go(16'hA588, 5'h04, 8'h0C, 8'h00, 0, 1, 16'h1111, 16'h0000);
    go(16'hA788, 5'h08, 8'h0E, 8'h00, 0, 2, 16'h1111, 16'h2222);
    go(16'hA789, 5'h10, 8'h0A, 8'h00, 0, 0, 16'h0000, 16'h0000);
    $display("test application done");
    go(16'h1234, 5'h1F, 8'h0A, 8'h00, 2, 0, 16'h0000, 16'h0000);
    go(16'h0688, 5'h1F, 8'h0D, 8'h04, 2, 0, 16'h0000, 16'h0000);
    go(16'hA08E, 5'h1F, 8'h0B, 8'h04, 2, 0, 16'h0000, 16'h0000);
    go(16'hA588, 5'h04, 8'h09, 8'h00, 2, 0, 16'h0000, 16'h0000);
    cmd_password = 32'h0BAD_0BAD;
    go(16'hA08B, 5'h00, 8'h0A, 8'h00, 1, 0, 16'h0000, 16'h0000);
    cmd_password = 32'hC0DE_5EED;
    mute = 1'b1;
    go(16'hA08B, 5'h00, 8'h0A, 8'h00, 3, 0, 16'h0000, 16'h0000);
    mute = 1'b0;
    go(16'hA08B, 5'h00, 8'h0A, 8'h00, 0, 0, 16'h0000, 16'h0000);
    $display("test refusals done");
    wrap_up;
  end
endmodule // tb
